/* File: bst_exec.sv */
// execution unit for bit-test skip and the two table read instructions
// assumes decode presents one instruction per cycle while instr_valid_i is high;
// data memory read data arrive combinationally for dmem_rd_addr_o
`timescale 1ns/10ps
`default_nettype none
module bst_exec
    import bst_pkg::*;
(
    input  wire logic               ref_clk_i,
    input  wire logic               sys_rst_i,
    input  wire logic               instr_valid_i,
    input  wire logic [1:0]         instr_op_i,
    input  wire logic [DADDR_W-1:0] instr_addr_i,
    input  wire logic [2:0]         instr_bit_i,
    input  wire logic [DATA_W-1:0]  table_pointer_i,
    input  wire logic [DATA_W-1:0]  dmem_rd_data_i,
    input  wire logic               pmem_wr_en_i,
    input  wire logic [PC_W-1:0]    pmem_wr_addr_i,
    input  wire logic [PWORD_W-1:0] pmem_wr_data_i,
    output logic                    instr_ready_o,
    output logic [DADDR_W-1:0]      dmem_rd_addr_o,
    output logic                    dmem_wr_en_o,
    output logic [DADDR_W-1:0]      dmem_wr_addr_o,
    output logic [DATA_W-1:0]       dmem_wr_data_o,
    output logic [DATA_W-1:0]       table_high_byte_o,
    output logic [PC_W-1:0]         pc_o,
    output logic                    skip_taken_o,
    output logic                    flags_wr_en_o
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [PC_W-1:0] tbl_addr(input logic [PAGE_W-1:0] page,
                                                  input logic [DATA_W-1:0] ptr);
        tbl_addr = {page, ptr};
    endfunction : tbl_addr

    // pc wraps at the top of program memory
    function automatic logic [PC_W-1:0] pc_plus(input logic [PC_W-1:0] pc,
                                                 input logic [1:0]      n);
        pc_plus = pc + PC_W'(n);
    endfunction : pc_plus

    // ****************************************************************
    // state
    // ****************************************************************
    bst_state_t          state;
    bst_state_t          next_state;
    logic [PC_W-1:0]     pc;
    logic [PC_W-1:0]     next_pc;
    logic [DATA_W-1:0]   tbh;
    logic [DATA_W-1:0]   next_tbh;
    // wr_addr and wr_data hold the last table write until the next one; wr_en is a one-cycle pulse
    logic                wr_en;
    logic                next_wr_en;
    logic [DADDR_W-1:0]  wr_addr;
    logic [DADDR_W-1:0]  next_wr_addr;
    logic [DATA_W-1:0]   wr_data;
    logic [DATA_W-1:0]   next_wr_data;
    logic                skip;
    logic                next_skip;
    logic [DADDR_W-1:0]  tbl_dest;
    logic [DADDR_W-1:0]  next_tbl_dest;
    logic [PC_W-1:0]     rom_addr;
    logic [PWORD_W-1:0]  rom_data;

    // registered read port: the table word is valid in the cycle after take
    bst_prog_rom u_rom (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (pmem_wr_en_i),
        .wr_addr_i (pmem_wr_addr_i),
        .wr_data_i (pmem_wr_data_i),
        .rd_addr_i (rom_addr),
        .rd_data_o (rom_data)
    );

    // ****************************************************************
    // table address selection
    // ****************************************************************
    always_comb
    begin
        if (instr_op_i == OP_TBL_LAST)
        begin
            rom_addr = tbl_addr(LAST_PAGE, table_pointer_i);
        end
        else
        begin
            rom_addr = tbl_addr(pc[PC_W-1 -: PAGE_W], table_pointer_i);
        end
    end

    // ready is a plain decode of the state register, no extra delay
    assign instr_ready_o  = (state == BST_EXEC);
    assign dmem_rd_addr_o = instr_addr_i;
    // none of these instructions touch the status flags
    assign flags_wr_en_o  = 1'b0;

    // ****************************************************************
    // instruction decode
    // ****************************************************************
    // taken only in the execute state; anything offered during the dummy
    // or table cycle is dropped without effect
    logic                take;
    logic                tested_bit_clear;

    assign take             = instr_valid_i && instr_ready_o;
    assign tested_bit_clear = (dmem_rd_data_i[instr_bit_i] == 1'b0);

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb
    begin
        next_state    = state;
        next_pc       = pc;
        next_tbh      = tbh;
        next_wr_en    = 1'b0;
        next_wr_addr  = wr_addr;
        next_wr_data  = wr_data;
        next_skip     = 1'b0;
        next_tbl_dest = tbl_dest;
        case (state)
            BST_EXEC:
            begin
                if (take)
                begin
                    case (instr_op_i)
                        OP_SKIP_BIT:
                        begin
                            if (tested_bit_clear)
                            begin
                                // pc moves past the skipped word now; the dummy
                                // cycle stands in for its fetch slot
                                next_pc    = pc_plus(pc, 2'h2);
                                next_skip  = 1'b1;
                                next_state = BST_DUMMY;
                            end
                            else
                            begin
                                next_pc = pc_plus(pc, 2'h1);
                            end
                        end
                        OP_TBL_CUR, OP_TBL_LAST:
                        begin
                            // rom word arrives one cycle later; OP_TBL_CUR takes the page from pc
                            // before the increment, so a page's last word reads its own page
                            next_tbl_dest = instr_addr_i;
                            next_pc       = pc_plus(pc, 2'h1);
                            next_state    = BST_TABLE;
                        end
                        default:
                        begin
                            next_pc = pc_plus(pc, 2'h1);
                        end
                    endcase
                end
            end
            BST_DUMMY:
            begin
                // dummy cycle while the instruction after the skipped one is fetched
                next_state = BST_EXEC;
            end
            BST_TABLE:
            begin
                next_wr_en   = 1'b1;
                next_wr_addr = tbl_dest;
                next_wr_data = rom_data[DATA_W-1:0];
                // program words are narrower than two bytes, top bit reads 0
                next_tbh     = {{(DATA_W-PHIGH_W){1'b0}}, rom_data[PWORD_W-1:DATA_W]};
                next_state   = BST_EXEC;
            end
            default:
            begin
                next_state = BST_EXEC;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            // a reset cancels any dummy or table cycle in flight
            state    <= BST_EXEC;
            pc       <= PC_RESET;
            tbh      <= TBH_RESET;
            wr_en    <= 1'b0;
            wr_addr  <= '0;
            wr_data  <= '0;
            skip     <= 1'b0;
            tbl_dest <= '0;
        end
        else
        begin
            state    <= next_state;
            pc       <= next_pc;
            tbh      <= next_tbh;
            wr_en    <= next_wr_en;
            wr_addr  <= next_wr_addr;
            wr_data  <= next_wr_data;
            skip     <= next_skip;
            tbl_dest <= next_tbl_dest;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign dmem_wr_en_o      = wr_en;
    assign dmem_wr_addr_o    = wr_addr;
    assign dmem_wr_data_o    = wr_data;
    assign table_high_byte_o = tbh;
    assign pc_o              = pc;
    assign skip_taken_o      = skip;

endmodule : bst_exec
`default_nettype wire

/* File: bst_pkg.sv */
// constants and types for the bit-test skip and table read execution unit
// assumes a single 250 MHz clock domain and a synchronous active-high reset
package bst_pkg;

    localparam int PC_W     = 11;
    localparam int DADDR_W  = 7;
    localparam int PWORD_W  = 15;
    localparam int PAGE_W   = 3;
    localparam int DATA_W   = 8;
    localparam int PHIGH_W  = PWORD_W - DATA_W;

    localparam logic [PAGE_W-1:0]  LAST_PAGE = 3'h7;
    localparam logic [PC_W-1:0]    PC_RESET  = 11'h000;
    localparam logic [DATA_W-1:0]  TBH_RESET = 8'h00;

    // opcode classes presented by the fetch/decode stage
    localparam logic [1:0] OP_OTHER    = 2'h0;
    localparam logic [1:0] OP_SKIP_BIT = 2'h1;
    localparam logic [1:0] OP_TBL_CUR  = 2'h2;
    localparam logic [1:0] OP_TBL_LAST = 2'h3;

    typedef enum logic [1:0] {
        BST_EXEC,
        BST_DUMMY,
        BST_TABLE
    } bst_state_t;

endpackage : bst_pkg

/* File: bst_prog_rom.sv */
// program memory: one synchronous read port, registered read data
// assumes contents are loaded by the surrounding device through the write port
`timescale 1ns/10ps
`default_nettype none
module bst_prog_rom
    import bst_pkg::*;
(
    input  wire logic               ref_clk_i,
    input  wire logic               wr_en_i,
    input  wire logic [PC_W-1:0]    wr_addr_i,
    input  wire logic [PWORD_W-1:0] wr_data_i,
    input  wire logic [PC_W-1:0]    rd_addr_i,
    output logic      [PWORD_W-1:0] rd_data_o
);

    logic [PWORD_W-1:0] mem [0:(1<<PC_W)-1];

    always_ff @(posedge ref_clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule : bst_prog_rom
`default_nettype wire

/* File: bst_exec_chk.sv */
// assertion checker for the bit-test skip and table read unit
// assumes one clock domain; bound onto every bst_exec instance
`timescale 1ns/10ps
`default_nettype none
module bst_exec_chk
    import bst_pkg::*;
(
    input wire logic               ref_clk_i,
    input wire logic               sys_rst_i,
    input wire logic               instr_valid_i,
    input wire logic [1:0]         instr_op_i,
    input wire logic [DADDR_W-1:0] instr_addr_i,
    input wire logic [2:0]         instr_bit_i,
    input wire logic [DATA_W-1:0]  dmem_rd_data_i,
    input wire logic               instr_ready_o,
    input wire logic               dmem_wr_en_o,
    input wire logic [DADDR_W-1:0] dmem_wr_addr_o,
    input wire logic [DATA_W-1:0]  table_high_byte_o,
    input wire logic [PC_W-1:0]    pc_o,
    input wire logic               skip_taken_o,
    input wire logic               flags_wr_en_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic tk;
    logic bz;
    assign tk = instr_valid_i && instr_ready_o && (instr_op_i == OP_SKIP_BIT);
    assign bz = !dmem_rd_data_i[instr_bit_i];
    property p_skip; tk && bz |=> skip_taken_o && pc_o == $past(pc_o) + 11'h002; endproperty
    a_skip: assert property (p_skip) else $error("skip not taken");
    property p_dummy; skip_taken_o |-> !instr_ready_o ##1 instr_ready_o; endproperty
    a_dummy: assert property (p_dummy) else $error("dummy cycle wrong");
    property p_noskip; tk && !bz |=> !skip_taken_o && pc_o == $past(pc_o) + 11'h001; endproperty
    a_noskip: assert property (p_noskip) else $error("skip wrongly taken");
    property p_tbl;
        instr_valid_i && instr_ready_o && instr_op_i[1] |=> !instr_ready_o ##1
            dmem_wr_en_o && dmem_wr_addr_o == $past(instr_addr_i, 2);
    endproperty
    a_tbl: assert property (p_tbl) else $error("table write wrong");
    property p_pulse; dmem_wr_en_o |=> !dmem_wr_en_o; endproperty
    a_pulse: assert property (p_pulse) else $error("write not a pulse");
    property p_tbh; $changed(table_high_byte_o) |-> dmem_wr_en_o && !table_high_byte_o[7]; endproperty
    a_tbh: assert property (p_tbh) else $error("high byte changed alone");
    property p_flags; flags_wr_en_o == 1'b0; endproperty
    a_flags: assert property (p_flags) else $error("flags written");
    property p_refuse; instr_valid_i && !instr_ready_o |=> $stable(pc_o); endproperty
    a_refuse: assert property (p_refuse) else $error("refused op moved pc");
endmodule : bst_exec_chk
bind bst_exec bst_exec_chk u_chk (.ref_clk_i, .sys_rst_i, .instr_valid_i, .instr_op_i,
    .instr_addr_i, .instr_bit_i, .dmem_rd_data_i, .instr_ready_o, .dmem_wr_en_o,
    .dmem_wr_addr_o, .table_high_byte_o, .pc_o, .skip_taken_o, .flags_wr_en_o);
`default_nettype wire

/* File: bst_exec_tb.sv */
// self-checking bench for the bit-test skip and table read unit
// assumes the package, design and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end
module bst_exec_tb
    import bst_pkg::*;
;
    logic               ref_clk_i = 1'b0;
    logic               sys_rst_i = 1'b1;
    logic               instr_valid_i = 1'b0;
    logic [1:0]         instr_op_i = OP_OTHER;
    logic [DADDR_W-1:0] instr_addr_i = '0;
    logic [2:0]         instr_bit_i = '0;
    logic [DATA_W-1:0]  table_pointer_i = '0;
    logic [DATA_W-1:0]  dmem_rd_data_i = '0;
    logic               pmem_wr_en_i = 1'b0;
    logic [PC_W-1:0]    pmem_wr_addr_i = '0;
    logic [PWORD_W-1:0] pmem_wr_data_i = '0;
    logic               instr_ready_o, dmem_wr_en_o, skip_taken_o, flags_wr_en_o;
    logic [DADDR_W-1:0] dmem_rd_addr_o, dmem_wr_addr_o;
    logic [DATA_W-1:0]  dmem_wr_data_o, table_high_byte_o;
    logic [PC_W-1:0]    pc_o;
    int                 failures = 0;
    int                 comparisons = 0;
    bst_exec DUT (.ref_clk_i, .sys_rst_i, .instr_valid_i, .instr_op_i, .instr_addr_i,
        .instr_bit_i, .table_pointer_i, .dmem_rd_data_i, .pmem_wr_en_i, .pmem_wr_addr_i,
        .pmem_wr_data_i, .instr_ready_o, .dmem_rd_addr_o, .dmem_wr_en_o, .dmem_wr_addr_o,
        .dmem_wr_data_o, .table_high_byte_o, .pc_o, .skip_taken_o, .flags_wr_en_o);
    always #2 ref_clk_i = ~ref_clk_i;
    task close_out;
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task load(input logic [PC_W-1:0] a, input logic [PWORD_W-1:0] w);
        @(posedge ref_clk_i);
        pmem_wr_en_i   <= 1'b1;
        pmem_wr_addr_i <= a;
        pmem_wr_data_i <= w;
        @(posedge ref_clk_i);
        pmem_wr_en_i <= 1'b0;
    endtask : load
    // hold keeps the request up into the dummy cycle, where it must be ignored
    task issue(input logic [1:0] op, input logic [7:0] a, input logic [2:0] b,
               input logic [7:0] d, input logic hold);
        if (instr_ready_o !== 1'b1)
        begin
            failures++;
            $display("mismatch %0t instruction port not ready", $time);
            close_out();
        end
        @(posedge ref_clk_i);
        instr_valid_i   <= 1'b1;
        instr_op_i      <= op;
        instr_addr_i    <= a[6:0];
        table_pointer_i <= a;
        instr_bit_i     <= b;
        dmem_rd_data_i  <= d;
        @(posedge ref_clk_i);
        if (hold)
            @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask : issue
    task skip_case(input logic [2:0] b, input logic [7:0] d, input logic hold);
        logic [PC_W-1:0] pc0;
        logic            tk;
        pc0 = pc_o;
        tk  = ~d[b];
        issue(OP_SKIP_BIT, 8'h11, b, d, hold);
        `CHK(dmem_rd_addr_o, 7'h11)
        if (!hold)
        begin
            `CHK(skip_taken_o, tk)
            `CHK(instr_ready_o, ~tk)
        end
        @(posedge ref_clk_i);
        #1;
        `CHK(pc_o, pc0 + (tk ? 11'h002 : 11'h001))
        `CHK(skip_taken_o, 1'b0)
        `CHK(flags_wr_en_o, 1'b0)
    endtask : skip_case
    task tbl_case(input logic [1:0] op, input logic [7:0] a, input logic [PWORD_W-1:0] w);
        logic [PC_W-1:0] pc0;
        pc0 = pc_o;
        issue(op, a, 3'h0, 8'h00, 1'b0);
        `CHK(pc_o, pc0 + 11'h001)
        `CHK(instr_ready_o, 1'b0)
        @(posedge ref_clk_i);
        #1;
        `CHK(dmem_wr_en_o, 1'b1)
        `CHK(dmem_wr_addr_o, a[6:0])
        `CHK(dmem_wr_data_o, w[7:0])
        `CHK(table_high_byte_o, {1'b0, w[14:8]})
    endtask : tbl_case
    task reset_case;
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        `CHK(pc_o, PC_RESET)
        `CHK(table_high_byte_o, TBH_RESET)
        `CHK(instr_ready_o, 1'b1)
        `CHK(skip_taken_o, 1'b0)
    endtask : reset_case
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        `CHK(pc_o, PC_RESET)
        `CHK(table_high_byte_o, TBH_RESET)
        `CHK(dmem_wr_en_o, 1'b0)
        load(11'h05A, 15'h6B3C);
        load(11'h75A, 15'h14C3);
        load(11'h0A5, 15'h7F81);
        load(11'h7A5, 15'h0255);
        load(11'h15A, 15'h3A96);
        for (int i = 0; i < 8; i++)
        begin
            skip_case(i[2:0], 8'h01 << i, 1'b0);
            skip_case(i[2:0], ~(8'h01 << i), 1'b0);
        end
        skip_case(3'h5, 8'h00, 1'b1);
        tbl_case(OP_TBL_CUR, 8'h5A, 15'h6B3C);
        tbl_case(OP_TBL_LAST, 8'h5A, 15'h14C3);
        tbl_case(OP_TBL_CUR, 8'hA5, 15'h7F81);
        tbl_case(OP_TBL_LAST, 8'hA5, 15'h0255);
        // walk pc into page 1 with plain instructions
        for (int n = 0; n < 300 && pc_o < 11'h100; n++)
        begin
            issue(OP_OTHER, 8'h00, 3'h0, 8'h00, 1'b0);
        end
        `CHK(pc_o, 11'h100)
        tbl_case(OP_TBL_CUR, 8'h5A, 15'h3A96);
        tbl_case(OP_TBL_LAST, 8'h5A, 15'h14C3);
        reset_case();
        skip_case(3'h2, 8'h00, 1'b0);
        close_out();
    end
endmodule : bst_exec_tb
`default_nettype wire
